// [verilog/ccrs_defs.svh]
// Register offsets, field positions and reset values of the core control slave.
// Assumes a 32-bit AXI4-Lite bus with byte addresses and one word per register.
`ifndef CCRS_DEFS_SVH
`define CCRS_DEFS_SVH

// Byte offsets of the registers.
`define CCRS_ADDR_W 8
`define CCRS_OFF_CTRL 8'h00
`define CCRS_OFF_GIE 8'h04
`define CCRS_OFF_IER 8'h08
`define CCRS_OFF_ISR 8'h0c
`define CCRS_OFF_PIN 8'h10
`define CCRS_OFF_PIN_HS 8'h14
`define CCRS_OFF_POUT 8'h18
`define CCRS_OFF_POUT_HS 8'h1c
`define CCRS_OFF_NARR 8'h20
`define CCRS_OFF_WARR 8'h30

// Control register bits.
`define CCRS_CTRL_LAUNCH 0
`define CCRS_CTRL_FINISHED 1
`define CCRS_CTRL_QUIESCENT 2
`define CCRS_CTRL_ACCEPTS 3
`define CCRS_CTRL_PROCEED 4
`define CCRS_CTRL_AUTO 7

// Interrupt source bits, handshake bits.
`define CCRS_IRQ_FINISHED 0
`define CCRS_IRQ_ACCEPTS 1
`define CCRS_HS_VALID 0
`define CCRS_HS_ACK 1

// Array geometry: 8-bit elements packed four to a word, 64-bit elements over two.
`define CCRS_NARR_WORDS 2
`define CCRS_WARR_WORDS 4
`define CCRS_WORD_SEL 3:2

// Reset values.
`define CCRS_RST_WORD 32'h0000_0000
`define CCRS_RST_BIT 1'b0
`define CCRS_RST_ONE 1'b1
`define CCRS_RST_IRQ 2'h0

`endif

// [verilog/ccrs_pkg.sv]
// Types shared by the core control slave.
// Assumes the constants of ccrs_defs.svh for offsets and fields.
package ccrs_pkg;

    // AXI response codes.
    typedef enum logic [1:0] {
        CCRS_RESP_OKAY = 2'h0,
        CCRS_RESP_DECERR = 2'h3
    } ccrs_resp_t;

    // One bus word.
    typedef logic [31:0] ccrs_word_t;

endpackage

// [verilog/ccrs_slave.sv]
// AXI4-Lite register slave that launches and watches one compute core.
// Assumes the core shares sys_clk_i and rst_n_i, so its signals need no synchroniser.
// Summary of operation
// - Launch write drives core launch signal.
// - Finished bit reads core finished directly.
// - Quiescent bit reads core idle directly.
// - Accepts bit reads core ready directly.
// - Proceed write pulses core proceed signal.
// - Auto-restart bit set and cleared by software.
// - Auto relaunch on finish, or chained on ready.
// - Input parameter register drives core input.
// - Software write raises input parameter valid.
// - Software write pulses output parameter acknowledge.
// - Output parameter value is readable.
// - Output parameter valid is readable.
// - Input parameter acknowledge is readable.
// - Narrow array elements packed four per word.
// - Wide array elements span consecutive words.
// - Global enable gates the interrupt output.
// - Two sources: finished and accepts input.
// - Each status bit cleared by software write.
// - Enabled sources readable back.
// - Triggered sources readable regardless of output.
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
`include "ccrs_defs.svh"

module ccrs_slave
    import ccrs_pkg::*;
#(
    // One selects the chained control protocol for auto-restart.
    parameter bit CHAINED = 1'b0
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // AXI4-Lite write address and data.
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [`CCRS_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    // AXI4-Lite write response.
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    // AXI4-Lite read.
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [`CCRS_ADDR_W-1:0] s_axi_araddr_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    // Block-level core control.
    output logic core_launch_o,
    input wire logic core_finished_i,
    input wire logic core_quiescent_i,
    input wire logic core_accepts_input_i,
    output logic core_proceed_o,
    // Scalar input parameter with two-way handshake.
    output logic [31:0] param_in_o,
    output logic param_in_valid_o,
    input wire logic param_in_acknowledge_i,
    // Scalar output parameter with two-way handshake.
    input wire logic [31:0] param_out_i,
    input wire logic param_out_valid_i,
    output logic param_out_acknowledge_o,
    // Arrays held in the register space.
    output logic [63:0] narrow_array_o,
    output logic [127:0] wide_array_o,
    // Interrupt.
    output logic core_irq_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Functions.
    // Merges a written word into an old one under the byte strobes.
    function automatic ccrs_word_t merge_bytes(input ccrs_word_t old_w,
                                               input ccrs_word_t new_w,
                                               input logic [3:0] strb);
        ccrs_word_t res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.
    logic awready_reg; // Address slot free.
    logic wready_reg; // Data slot free.
    logic bvalid_reg; // Write response pending.
    logic [1:0] bresp_reg; // Write response code.
    logic [`CCRS_ADDR_W-1:0] awaddr_reg; // Captured write address.
    ccrs_word_t wdata_reg; // Captured write data.
    logic [3:0] wstrb_reg; // Captured strobes.
    logic arready_reg; // Read address slot free.
    logic rvalid_reg; // Read data pending.
    logic [1:0] rresp_reg; // Read response code.
    ccrs_word_t rdata_reg; // Read data.
    logic launch_reg; // Core launch level.
    logic proceed_reg; // Core proceed pulse.
    logic auto_reg; // Auto-restart setting.
    logic gie_reg; // Global interrupt enable.
    logic [1:0] ier_reg; // Per-source enables.
    logic [1:0] isr_reg; // Latched sources.
    logic irq_reg; // Interrupt output.
    logic fin_d_reg; // Finished one cycle ago.
    logic acc_d_reg; // Accepts input one cycle ago.
    ccrs_word_t pin_reg; // Input parameter.
    logic pin_vld_reg; // Input parameter valid.
    logic pout_ack_reg; // Output parameter acknowledge pulse.
    ccrs_word_t narr_reg [`CCRS_NARR_WORDS]; // Packed byte array.
    ccrs_word_t warr_reg [`CCRS_WARR_WORDS]; // Wide element array.
    logic wr_go; // Both write halves held, response slot free.
    logic wr_ctrl; // Write to the control register.
    logic wr_isr; // Write to the status register.
    logic [1:0] isr_rise; // Source rising edges.
    logic [1:0] isr_next; // Next status value.
    ccrs_word_t rd_next; // Read data for the read address on the bus input.
    logic rd_bad; // Read address unmapped.
    logic wr_bad; // Write address unmapped.

    assign wr_go = !awready_reg && !wready_reg && !bvalid_reg;
    assign wr_ctrl = wr_go && awaddr_reg == `CCRS_OFF_CTRL && wstrb_reg[0];
    assign wr_isr = wr_go && awaddr_reg == `CCRS_OFF_ISR && wstrb_reg[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Write channels: address and data are taken in any order, then answered.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            awready_reg <= `CCRS_RST_ONE;
            wready_reg <= `CCRS_RST_ONE;
            bvalid_reg <= `CCRS_RST_BIT;
            bresp_reg <= CCRS_RESP_OKAY;
            awaddr_reg <= '0;
            wdata_reg <= `CCRS_RST_WORD;
            wstrb_reg <= '0;
        end else begin
            // Address taken: hold until the response is accepted.
            if (awready_reg && s_axi_awvalid_i) begin
                awready_reg <= `CCRS_RST_BIT;
                awaddr_reg <= s_axi_awaddr_i;
            end
            // Data taken likewise.
            if (wready_reg && s_axi_wvalid_i) begin
                wready_reg <= `CCRS_RST_BIT;
                wdata_reg <= s_axi_wdata_i;
                wstrb_reg <= s_axi_wstrb_i;
            end
            // Both halves in hand: the write lands now and the answer follows.
            if (wr_go) begin
                bvalid_reg <= `CCRS_RST_ONE;
                bresp_reg <= wr_bad ? CCRS_RESP_DECERR : CCRS_RESP_OKAY;
            end else if (bvalid_reg && s_axi_bready_i) begin
                bvalid_reg <= `CCRS_RST_BIT;
                awready_reg <= `CCRS_RST_ONE;
                wready_reg <= `CCRS_RST_ONE;
            end
        end
    end

    // Flags a write address that maps to no register.
    always_comb begin
        wr_bad = 1'b1;
        if (awaddr_reg <= `CCRS_OFF_POUT_HS) begin
            wr_bad = 1'b0;
        end else if (awaddr_reg >= `CCRS_OFF_NARR
                     && awaddr_reg < `CCRS_OFF_NARR + 8'(4 * `CCRS_NARR_WORDS)) begin
            wr_bad = 1'b0;
        end else if (awaddr_reg >= `CCRS_OFF_WARR
                     && awaddr_reg < `CCRS_OFF_WARR + 8'(4 * `CCRS_WARR_WORDS)) begin
            wr_bad = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Core control: launch, proceed and auto-restart.
    // Launch rises on a software write and on non-chained auto-restart; drops when the core takes it unless chained auto-restart is on.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            launch_reg <= `CCRS_RST_BIT;
            auto_reg <= `CCRS_RST_BIT;
        end else begin
            if (wr_ctrl) begin
                auto_reg <= wdata_reg[`CCRS_CTRL_AUTO];
            end
            if (wr_ctrl && wdata_reg[`CCRS_CTRL_LAUNCH]) begin
                launch_reg <= `CCRS_RST_ONE;
            end else if (auto_reg && !CHAINED && core_finished_i) begin
                launch_reg <= `CCRS_RST_ONE;
            end else if (core_accepts_input_i && !(auto_reg && CHAINED)) begin
                // Chained auto-restart keeps launch up across ready.
                launch_reg <= `CCRS_RST_BIT;
            end
        end
    end

    // Proceed is a one-cycle pulse from software, or follows finished one cycle late while chained and auto.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            proceed_reg <= `CCRS_RST_BIT;
        end else begin
            proceed_reg <= (wr_ctrl && wdata_reg[`CCRS_CTRL_PROCEED])
                           || (CHAINED && auto_reg && core_finished_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Scalar parameters.
    // Input value and valid; valid holds until the core acknowledges.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_reg <= `CCRS_RST_WORD;
            pin_vld_reg <= `CCRS_RST_BIT;
            pout_ack_reg <= `CCRS_RST_BIT;
        end else begin
            if (wr_go && awaddr_reg == `CCRS_OFF_PIN) begin
                pin_reg <= merge_bytes(pin_reg, wdata_reg, wstrb_reg);
            end
            if (wr_go && awaddr_reg == `CCRS_OFF_PIN_HS && wstrb_reg[0]
                && wdata_reg[`CCRS_HS_VALID]) begin
                pin_vld_reg <= `CCRS_RST_ONE;
            end else if (param_in_acknowledge_i) begin
                pin_vld_reg <= `CCRS_RST_BIT;
            end
            // Acknowledge for the output parameter lasts one cycle.
            pout_ack_reg <= wr_go && awaddr_reg == `CCRS_OFF_POUT_HS && wstrb_reg[0]
                            && wdata_reg[`CCRS_HS_ACK];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Arrays: bytes share a word, wide elements occupy word pairs, low half first.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < `CCRS_NARR_WORDS; i++) begin
                narr_reg[i] <= `CCRS_RST_WORD;
            end
            for (int i = 0; i < `CCRS_WARR_WORDS; i++) begin
                warr_reg[i] <= `CCRS_RST_WORD;
            end
        end else if (wr_go && !wr_bad) begin
            if (awaddr_reg >= `CCRS_OFF_WARR) begin
                warr_reg[awaddr_reg[`CCRS_WORD_SEL]] <=
                    merge_bytes(warr_reg[awaddr_reg[`CCRS_WORD_SEL]], wdata_reg,
                                wstrb_reg);
            end else if (awaddr_reg >= `CCRS_OFF_NARR) begin
                narr_reg[awaddr_reg[2]] <=
                    merge_bytes(narr_reg[awaddr_reg[2]], wdata_reg, wstrb_reg);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts.
    assign isr_rise = {core_accepts_input_i && !acc_d_reg, core_finished_i && !fin_d_reg};

    // A rising source sets its bit even in the cycle software clears it.
    always_comb begin
        isr_next = isr_reg;
        if (wr_isr) begin
            isr_next = isr_reg & ~wdata_reg[1:0];
        end
        isr_next = isr_next | isr_rise;
    end

    // Enables, status and the gated output.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gie_reg <= `CCRS_RST_BIT;
            ier_reg <= `CCRS_RST_IRQ;
            isr_reg <= `CCRS_RST_IRQ;
            irq_reg <= `CCRS_RST_BIT;
            fin_d_reg <= `CCRS_RST_BIT;
            acc_d_reg <= `CCRS_RST_BIT;
        end else begin
            fin_d_reg <= core_finished_i;
            acc_d_reg <= core_accepts_input_i;
            if (wr_go && awaddr_reg == `CCRS_OFF_GIE && wstrb_reg[0]) begin
                gie_reg <= wdata_reg[0];
            end
            if (wr_go && awaddr_reg == `CCRS_OFF_IER && wstrb_reg[0]) begin
                ier_reg <= wdata_reg[1:0];
            end
            isr_reg <= isr_next;
            irq_reg <= gie_reg && |(ier_reg & isr_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path: decode the address, answer one cycle after it is taken.
    always_comb begin
        rd_next = `CCRS_RST_WORD;
        rd_bad = 1'b0;
        if (s_axi_araddr_i == `CCRS_OFF_CTRL) begin
            rd_next[`CCRS_CTRL_LAUNCH] = launch_reg;
            rd_next[`CCRS_CTRL_FINISHED] = core_finished_i;
            rd_next[`CCRS_CTRL_QUIESCENT] = core_quiescent_i;
            rd_next[`CCRS_CTRL_ACCEPTS] = core_accepts_input_i;
            rd_next[`CCRS_CTRL_AUTO] = auto_reg;
        end else if (s_axi_araddr_i == `CCRS_OFF_GIE) begin
            rd_next[0] = gie_reg;
        end else if (s_axi_araddr_i == `CCRS_OFF_IER) begin
            rd_next[1:0] = ier_reg;
        end else if (s_axi_araddr_i == `CCRS_OFF_ISR) begin
            rd_next[1:0] = isr_reg;
        end else if (s_axi_araddr_i == `CCRS_OFF_PIN) begin
            rd_next = pin_reg;
        end else if (s_axi_araddr_i == `CCRS_OFF_PIN_HS) begin
            rd_next[`CCRS_HS_VALID] = pin_vld_reg;
            rd_next[`CCRS_HS_ACK] = param_in_acknowledge_i;
        end else if (s_axi_araddr_i == `CCRS_OFF_POUT) begin
            rd_next = param_out_i;
        end else if (s_axi_araddr_i == `CCRS_OFF_POUT_HS) begin
            rd_next[`CCRS_HS_VALID] = param_out_valid_i;
        end else if (s_axi_araddr_i >= `CCRS_OFF_NARR
                     && s_axi_araddr_i < `CCRS_OFF_NARR + 8'(4 * `CCRS_NARR_WORDS)) begin
            rd_next = narr_reg[s_axi_araddr_i[2]];
        end else if (s_axi_araddr_i >= `CCRS_OFF_WARR
                     && s_axi_araddr_i < `CCRS_OFF_WARR + 8'(4 * `CCRS_WARR_WORDS)) begin
            rd_next = warr_reg[s_axi_araddr_i[`CCRS_WORD_SEL]];
        end else begin
            rd_bad = 1'b1;
        end
    end

    // Read handshake: one read in flight at a time.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            arready_reg <= `CCRS_RST_ONE;
            rvalid_reg <= `CCRS_RST_BIT;
            rresp_reg <= CCRS_RESP_OKAY;
            rdata_reg <= `CCRS_RST_WORD;
        end else if (arready_reg && s_axi_arvalid_i) begin
            arready_reg <= `CCRS_RST_BIT;
            rvalid_reg <= `CCRS_RST_ONE;
            rdata_reg <= rd_next;
            rresp_reg <= rd_bad ? CCRS_RESP_DECERR : CCRS_RESP_OKAY;
        end else if (rvalid_reg && s_axi_rready_i) begin
            rvalid_reg <= `CCRS_RST_BIT;
            arready_reg <= `CCRS_RST_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops.
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign core_launch_o = launch_reg;
    assign core_proceed_o = proceed_reg;
    assign param_in_o = pin_reg;
    assign param_in_valid_o = pin_vld_reg;
    assign param_out_acknowledge_o = pout_ack_reg;
    assign narrow_array_o = {narr_reg[1], narr_reg[0]};
    assign wide_array_o = {warr_reg[3], warr_reg[2], warr_reg[1], warr_reg[0]};
    assign core_irq_o = irq_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    launch_write_a: assert property (wr_ctrl && wdata_reg[0] |=> core_launch_o)
        else $error("launch not raised after write");
    finished_read_a: assert property (s_axi_arvalid_i && arready_reg
        && s_axi_araddr_i == `CCRS_OFF_CTRL |=> s_axi_rdata_o[1] == $past(core_finished_i))
        else $error("finished bit wrong");
    idle_read_a: assert property (s_axi_arvalid_i && arready_reg
        && s_axi_araddr_i == `CCRS_OFF_CTRL |=> s_axi_rdata_o[2] == $past(core_quiescent_i))
        else $error("quiescent bit wrong");
    ready_read_a: assert property (s_axi_arvalid_i && arready_reg
        && s_axi_araddr_i == `CCRS_OFF_CTRL |=> s_axi_rdata_o[3] == $past(core_accepts_input_i))
        else $error("accepts bit wrong");
    proceed_write_a: assert property (wr_ctrl && wdata_reg[4] |=> core_proceed_o)
        else $error("proceed not pulsed");
    auto_launch_a: assert property (auto_reg && !CHAINED && core_finished_i
        |=> core_launch_o) else $error("no auto relaunch");
    param_drive_a: assert property (wr_go && awaddr_reg == `CCRS_OFF_PIN
        && wstrb_reg == 4'hf |=> param_in_o == $past(wdata_reg)) else $error("param wrong");
    src_latch_a: assert property ($rose(core_finished_i) |=> isr_reg[0])
        else $error("finished source not latched");
    irq_gate_a: assert property (!gie_reg |=> !core_irq_o)
        else $error("interrupt not gated");
    isr_clear_a: assert property (wr_isr && wdata_reg[1] && !isr_rise[1]
        |=> !isr_reg[1]) else $error("status not cleared");
    pin_ack_read_a: assert property (s_axi_arvalid_i && arready_reg
        && s_axi_araddr_i == `CCRS_OFF_PIN_HS |=> s_axi_rdata_o[1]
        == $past(param_in_acknowledge_i)) else $error("ack bit wrong");
    cover_launch_c: cover property (wr_ctrl && wdata_reg[0] ##[1:20] core_accepts_input_i);
    cover_irq_c: cover property ($rose(core_irq_o));
    cover_decerr_c: cover property (rvalid_reg && rresp_reg == CCRS_RESP_DECERR);
endmodule

// [verification/ccrs_core_model.sv]
// Behavioural model of the compute core behind the control slave.
// Assumes the slave's clock and reset; the core runs a fixed number of busy cycles.
`timescale 1ns/1ns

module ccrs_core_model #(
    parameter int BUSY = 6
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Control from the slave.
    input wire logic core_launch_i,
    input wire logic param_in_valid_i,
    input wire logic [31:0] param_in_i,
    input wire logic param_out_acknowledge_i,
    // Status toward the slave.
    output logic core_finished_o,
    output logic core_quiescent_o,
    output logic core_accepts_input_o,
    output logic param_in_acknowledge_o,
    output logic [31:0] param_out_o,
    output logic param_out_valid_o
);
    logic [3:0] cnt_reg; // Busy cycles left.

    ////////////////////////////////////////////////////////////////////////////////
    // Take a launch while idle, then finish after BUSY cycles and hold finished.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_finished_o <= 1'b0;
            core_quiescent_o <= 1'b1;
            core_accepts_input_o <= 1'b0;
            cnt_reg <= 4'h0;
        end else begin
            core_accepts_input_o <= 1'b0;
            if (core_quiescent_o && core_launch_i) begin
                core_accepts_input_o <= 1'b1;
                core_quiescent_o <= 1'b0;
                core_finished_o <= 1'b0;
                cnt_reg <= 4'(BUSY);
            end else if (!core_quiescent_o) begin
                // Finished stays high until the next launch is taken.
                core_quiescent_o <= (cnt_reg == 4'h1);
                core_finished_o <= (cnt_reg == 4'h1);
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Acknowledge a valid input at once; publish input plus one when a run ends.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            param_in_acknowledge_o <= 1'b0;
            param_out_o <= 32'h0000_0000;
            param_out_valid_o <= 1'b0;
        end else begin
            param_in_acknowledge_o <= param_in_valid_i && !param_in_acknowledge_o;
            if (!core_quiescent_o && cnt_reg == 4'h1) begin
                param_out_o <= param_in_i + 32'h0000_0001;
                param_out_valid_o <= 1'b1;
            end else if (param_out_acknowledge_i) begin
                param_out_valid_o <= 1'b0;
            end
        end
    end
endmodule

// [verification/core_control_register_slave_tb.sv]
// Self-checking bench for the core control slave, driven over AXI4-Lite.
// Assumes the core model above stands on the far side of the slave.
`timescale 1ns/1ns

module core_control_register_slave_tb;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    logic awr, wr, bv, arr, rv, launch, fin, qui, acc, proc, piv, pia, poa, pov, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] pin, pout, rdata;
    logic [63:0] narr;
    logic [127:0] warr;
    int num_errors = 0, compares = 0, cyc = 0, n_run = 0, n_proc = 0, n_ack = 0, n;

    initial forever #2 sys_clk_i = ~sys_clk_i;

    ccrs_slave u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
        .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .core_launch_o(launch), .core_finished_i(fin),
        .core_quiescent_i(qui), .core_accepts_input_i(acc), .core_proceed_o(proc),
        .param_in_o(pin), .param_in_valid_o(piv), .param_in_acknowledge_i(pia),
        .param_out_i(pout), .param_out_valid_i(pov), .param_out_acknowledge_o(poa),
        .narrow_array_o(narr), .wide_array_o(warr), .core_irq_o(irq));

    ccrs_core_model u_core (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .core_launch_i(launch),
        .param_in_valid_i(piv), .param_in_i(pin), .param_out_acknowledge_i(poa),
        .core_finished_o(fin), .core_quiescent_o(qui), .core_accepts_input_o(acc),
        .param_in_acknowledge_o(pia), .param_out_o(pout), .param_out_valid_o(pov));

    ////////////////////////////////////////////////////////////////////////////////
    // Count taken launches, proceed pulses and input acknowledges; cut a hang short.
    always @(posedge sys_clk_i) begin
        cyc++;
        if (rst_n_i && launch && acc) n_run++;
        if (rst_n_i && proc) n_proc++;
        if (rst_n_i && pia) n_ack++;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up;
        end
    end

    // Compare one value and report a mismatch.
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    // Write one word; address and data are offered together and released when taken.
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; br <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        br <= 1'b0;
    endtask

    // Read one word; the data and response are taken at the rvalid edge.
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk_i);
        arv <= 1'b1; ara <= a; rr <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            if (arr) arv <= 1'b0;
        end while (!rv);
        d = rdata; r = rresp; rr <= 1'b0;
    endtask

    // Read and compare masked bits.
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [1:0] r;
        axr(a, rd, r);
        chk($sformatf("reg %h", a), e, rd & m);
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
    endtask

    // Print the counts and the verdict, then end the run.
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence of tests.
    initial begin
        logic [1:0] rsp;
        wait_cyc(20);
        rst_n_i <= 1'b1;
        rchk(8'h00, 32'hffff_ffff, 32'h0000_0004);
        rchk(8'h08, 32'hffff_ffff, 32'h0000_0000);
        chk("irq", 32'h0, {31'h0, irq});
        axr(8'h80, rd, rsp);
        chk("unmapped resp", 32'h3, {30'h0, rsp});
        chk("unmapped data", 32'h0, rd);
        axw(8'h80, 32'h1);
        chk("unmapped bresp", 32'h3, {30'h0, bresp});
        $display("reset and map test done");
        axw(8'h10, 32'h1234_5678);
        wait_cyc(2);
        chk("param in", 32'h1234_5678, pin);
        chk("bresp", 32'h0, {30'h0, bresp});
        axw(8'h14, 32'h0000_0001);
        wait_cyc(4);
        chk("input acks", 32'h1, 32'(n_ack));
        chk("input valid", 32'h0, {31'h0, piv});
        axw(8'h20, 32'h4433_2211);
        axw(8'h34, 32'hdead_beef);
        wait_cyc(2);
        chk("narrow", 32'h4433_2211, narr[31:0]);
        chk("wide", 32'hdead_beef, warr[63:32]);
        rchk(8'h34, 32'hffff_ffff, 32'hdead_beef);
        $display("parameter and array test done");
        axw(8'h04, 32'h1);
        axw(8'h08, 32'h3);
        axw(8'h00, 32'h1);
        wait_cyc(14);
        chk("runs", 32'h1, 32'(n_run));
        rchk(8'h00, 32'h0000_00ff, 32'h0000_0006);
        rchk(8'h0c, 32'hffff_ffff, 32'h0000_0003);
        chk("irq on", 32'h1, {31'h0, irq});
        rchk(8'h18, 32'hffff_ffff, 32'h1234_5679);
        rchk(8'h1c, 32'h1, 32'h1);
        axw(8'h1c, 32'h2);
        rchk(8'h1c, 32'h1, 32'h0);
        axw(8'h0c, 32'h1);
        rchk(8'h0c, 32'hffff_ffff, 32'h0000_0002);
        rchk(8'h08, 32'hffff_ffff, 32'h0000_0003);
        axw(8'h04, 32'h0);
        wait_cyc(3);
        chk("irq gated", 32'h0, {31'h0, irq});
        $display("launch and interrupt test done");
        axw(8'h00, 32'h80);
        wait_cyc(40);
        chk("auto runs", 32'h1, 32'(n_run > 3));
        rchk(8'h00, 32'h80, 32'h80);
        axw(8'h00, 32'h0);
        wait_cyc(14);
        n = n_run;
        wait_cyc(30);
        chk("auto off", 32'(n), 32'(n_run));
        axw(8'h00, 32'h10);
        wait_cyc(3);
        chk("proceed", 32'h1, 32'(n_proc));
        $display("restart and proceed test done");
        wrap_up;
    end
endmodule
